//--- include/cmc_map.vh
// Purpose: register map, field positions, reset values and timing counts of the commissioning control block
// Assumes: 32-bit AHB-Lite register bus, byte addresses, one aligned word per register
// Notes:   times are given in milliseconds and turned into clk_sys cycles here
`ifndef CMC_MAP_VH
`define CMC_MAP_VH

// ==========================================================================
// register byte offsets
`define CMC_OFS_CONFIG     8'h00
`define CMC_OFS_VARIANT    8'h04
`define CMC_OFS_PIN        8'h08
`define CMC_OFS_UNLOCK     8'h0C
`define CMC_OFS_KEY0       8'h10
`define CMC_OFS_SRC_LO     8'h20
`define CMC_OFS_SRC_HI     8'h24
`define CMC_OFS_MFR_ID     8'h28
`define CMC_OFS_SEQ        8'h2C
`define CMC_OFS_STATUS     8'h30

// ==========================================================================
// field positions
`define CMC_CFG_NO_LEARN   0
`define CMC_CFG_HIDE_KEY   1
`define CMC_ST_COMM        0
`define CMC_ST_LOCKED      1
`define CMC_ST_UNLOCKED    2
`define CMC_ST_KEY_HIDDEN  3
`define CMC_ST_ENTRY_LSB   4

// ==========================================================================
// reset and factory values
`define CMC_RST_CONFIG     8'h00
`define CMC_RST_VARIANT    8'h00
`define CMC_RST_PIN        32'h0000E215
`define CMC_RST_SEQ        32'h00000000

// ==========================================================================
// contact codes, bit 0 left low, 1 left high, 2 right low, 3 right high
`define CMC_CT_DISABLE     4'hB
`define CMC_CT_DIAG_A      4'h9
`define CMC_CT_DIAG_B      4'h6

// ==========================================================================
// timing
`define CMC_CLK_KHZ        125000
`define CMC_T_LONG_MS      7000
`define CMC_T_SHORT_MS     2000
`define CMC_T_TEN_MS       10000
`define CMC_T_LONG_CYC     (`CMC_T_LONG_MS * `CMC_CLK_KHZ)
`define CMC_T_SHORT_CYC    (`CMC_T_SHORT_MS * `CMC_CLK_KHZ)
`define CMC_T_TEN_CYC      (`CMC_T_TEN_MS * `CMC_CLK_KHZ)

`endif

//--- hw/cmc_top.v
// Purpose: commissioning mode control of a self-powered pushbutton transmitter
// Assumes: contact and bow inputs synchronous to clk_sys, clk_en freezes every flip-flop
// Notes:   the AHB-Lite slave stands for the tag-side configuration memory
//          contacts count only as present in the cycle the bow goes down
//          factory key, address and maker id load only on the reset gesture
//
// Design decisions made here: the register addresses and the AHB-Lite slave port.
`include "cmc_map.vh"

module cmc_top #(
	parameter [31:0]  T_LONG_CYC  = `CMC_T_LONG_CYC,
	parameter [31:0]  T_SHORT_CYC = `CMC_T_SHORT_CYC,
	parameter [31:0]  T_TEN_CYC   = `CMC_T_TEN_CYC,
	parameter [127:0] FACTORY_KEY = 128'h0123456789ABCDEF0F1E2D3C4B5A6978, // arbitrary value
	parameter [47:0]  FACTORY_SRC = 48'hC0FFEE123456,                      // arbitrary value
	parameter [15:0]  FACTORY_MFR = 16'h5A5A                               // arbitrary value
) (
	input  wire        clk_sys,
	input  wire        sys_rst,
	input  wire        clk_en,
	input  wire        energy_bow,
	input  wire        contact_left_low,
	input  wire        contact_left_high,
	input  wire        contact_right_low,
	input  wire        contact_right_high,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	output reg         tel_comm,
	output reg         tel_data,
	output reg         tel_press,
	output reg  [3:0]  tel_contacts,
	output reg         comm_mode,
	output reg         factory_reset_done
);

	// ==========================================================================
	// gesture states, one-hot
	localparam [2:0] G_IDLE  = 3'b001;
	localparam [2:0] G_LONG1 = 3'b010;
	localparam [2:0] G_SHORT = 3'b100;

	wire [3:0] contacts = {contact_right_high, contact_right_low, contact_left_high, contact_left_low};

	// ==========================================================================
	// gesture and telegram state
	reg         bow_q;
	reg  [31:0] hold_cnt_q;
	reg  [3:0]  press_ct_q;
	reg  [3:0]  entry_ct_q;
	reg  [2:0]  gstate_q;
	reg         locked_q;
	reg         freset_q;
	reg  [31:0] seq_q;

	// ==========================================================================
	// configuration memory words
	reg  [7:0]   config_q;
	reg  [7:0]   variant_q;
	reg  [31:0]  pin_q;
	reg  [127:0] key_q;
	reg  [47:0]  src_q;
	reg  [15:0]  mfr_q;
	reg          unlocked_q;
	reg          key_hidden_q;

	// ==========================================================================
	// bus data phase
	reg          wr_pend_q;
	reg          rd_pend_q;
	reg  [7:0]   addr_q;
	reg  [31:0]  rdata;

	// ==========================================================================
	// hold and gesture decodes
	wire bow_rise = energy_bow & ~bow_q;
	wire bow_fall = ~energy_bow & bow_q;
	wire single   = (press_ct_q != 4'h0) && ((press_ct_q & (press_ct_q - 4'h1)) == 4'h0);
	wire is_long  = hold_cnt_q > T_LONG_CYC;
	wire is_short = hold_cnt_q < T_SHORT_CYC;
	wire is_ten   = hold_cnt_q >= T_TEN_CYC;
	wire no_learn = config_q[`CMC_CFG_NO_LEARN];      // set by configurer
	wire entry_ok = (gstate_q == G_SHORT) && (press_ct_q == entry_ct_q) && is_long;
	wire wr_ok    = wr_pend_q && unlocked_q;

	// ==========================================================================
	// hold time base, restarts on each bow press
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			bow_q      <= 1'b0;
			hold_cnt_q <= 32'h00000000;
			press_ct_q <= 4'h0;
		end else if (clk_en) begin
			bow_q <= energy_bow;
			if (bow_rise) begin
				hold_cnt_q <= 32'h00000000;
				press_ct_q <= contacts;                 // contacts pressed with the bow
			end else if (energy_bow && hold_cnt_q != 32'hFFFFFFFF) begin
				// saturates, so a bow left down never wraps into a short press
				hold_cnt_q <= hold_cnt_q + 32'h00000001;
			end
		end
	end

	// ==========================================================================
	// gesture recognition, commissioning mode and telegram requests
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			gstate_q     <= G_IDLE;
			entry_ct_q   <= 4'h0;
			comm_mode    <= 1'b0;
			locked_q     <= 1'b0;
			freset_q     <= 1'b0;
			tel_comm     <= 1'b0;
			tel_data     <= 1'b0;
			tel_press    <= 1'b0;
			tel_contacts <= 4'h0;
			factory_reset_done <= 1'b0;
		end else if (clk_en) begin
			// telegram requests are one-cycle pulses
			tel_comm <= 1'b0;
			tel_data <= 1'b0;
			freset_q <= 1'b0;
			factory_reset_done <= freset_q;
			// press: one telegram at once, a foreign contact ends the mode
			if (bow_rise) begin
				tel_press    <= 1'b1;
				tel_contacts <= contacts;
				if (comm_mode && contacts == entry_ct_q) begin
					tel_comm <= 1'b1;
				end else begin
					tel_data <= 1'b1;
					if (comm_mode && contacts != 4'h0) begin
						comm_mode <= 1'b0;
					end
				end
			end else if (bow_fall) begin
				// release: reset and disable gestures win over entry
				tel_press    <= 1'b0;
				tel_contacts <= 4'h0;
				if (is_ten && (press_ct_q == `CMC_CT_DIAG_A || press_ct_q == `CMC_CT_DIAG_B)) begin
					freset_q  <= 1'b1;
					locked_q  <= 1'b0;
					comm_mode <= 1'b0;
					gstate_q  <= G_IDLE;
					tel_data  <= 1'b1;
				end else if (is_ten && press_ct_q == `CMC_CT_DISABLE) begin
					locked_q  <= 1'b1;
					comm_mode <= 1'b0;
					gstate_q  <= G_IDLE;
					tel_data  <= 1'b1;
				end else if (entry_ok) begin
					gstate_q <= G_IDLE;
					if (!no_learn && !locked_q) begin
						comm_mode <= 1'b1;
						tel_comm  <= 1'b1;
					end else begin
						tel_data <= 1'b1;
					end
				end else begin
					if (comm_mode && press_ct_q == entry_ct_q) begin
						tel_comm <= 1'b1;
					end else begin
						tel_data <= 1'b1;
					end
					// long-short-long tracker, a new long single press restarts it
					case (gstate_q)
						G_LONG1: begin
							if (press_ct_q == entry_ct_q && is_short) begin
								gstate_q <= G_SHORT;
							end else if (single && is_long) begin
								gstate_q   <= G_LONG1;
								entry_ct_q <= press_ct_q;
							end else begin
								gstate_q <= G_IDLE;
							end
						end
						default: begin
							if (single && is_long) begin
								gstate_q   <= G_LONG1;
								entry_ct_q <= press_ct_q;
							end else begin
								gstate_q <= G_IDLE;
							end
						end
					endcase
				end
			end
		end
	end

	// ==========================================================================
	// sequence counter, one step per telegram sent
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			seq_q <= `CMC_RST_SEQ;
		end else if (clk_en && (tel_comm || tel_data)) begin
			seq_q <= seq_q + 32'h00000001;
		end
	end

	// ==========================================================================
	// AHB-Lite slave: zero-wait writes, one wait state on reads
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			addr_q    <= 8'h00;
			hreadyout <= 1'b1;
			hrdata    <= 32'h00000000;
			hresp     <= 1'b0;
		end else if (clk_en) begin
			hresp     <= 1'b0;                          // always OKAY
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			// read data loads one cycle after the address phase
			if (rd_pend_q) begin
				hrdata    <= rdata;
				hreadyout <= 1'b1;
			end else if (hsel && htrans[1] && hready) begin
				addr_q    <= haddr[7:0];
				wr_pend_q <= hwrite;
				rd_pend_q <= ~hwrite;
				hreadyout <= hwrite;
			end
		end
	end

	// ==========================================================================
	// read mux, unmapped and write-only words read zero
	always @* begin
		rdata = 32'h00000000;
		case (addr_q)
			`CMC_OFS_CONFIG:  rdata = {24'h000000, config_q};
			`CMC_OFS_VARIANT: rdata = {24'h000000, variant_q};
			`CMC_OFS_PIN:     rdata = 32'h00000000;     // PIN never reads back
			`CMC_OFS_SRC_LO:  rdata = src_q[31:0];
			`CMC_OFS_SRC_HI:  rdata = {16'h0000, src_q[47:32]};
			`CMC_OFS_MFR_ID:  rdata = {16'h0000, mfr_q};
			`CMC_OFS_SEQ:     rdata = seq_q;
			`CMC_OFS_STATUS:  rdata = {24'h000000, entry_ct_q, key_hidden_q, unlocked_q, locked_q, comm_mode};
			`CMC_OFS_KEY0, `CMC_OFS_KEY0 + 8'h04, `CMC_OFS_KEY0 + 8'h08, `CMC_OFS_KEY0 + 8'h0C: begin
				if (!key_hidden_q) begin
					rdata = key_q[{addr_q[3:2], 5'h00} +: 32];
				end
			end
			default:          rdata = 32'h00000000;
		endcase
	end

	// ==========================================================================
	// configuration memory, factory reset has priority over software writes
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			config_q     <= `CMC_RST_CONFIG;
			variant_q    <= `CMC_RST_VARIANT;
			pin_q        <= `CMC_RST_PIN;
			src_q        <= 48'h000000000000;
			mfr_q        <= 16'h0000;
			unlocked_q   <= 1'b0;
			key_hidden_q <= 1'b0;
		end else if (clk_en) begin
			if (freset_q) begin
				config_q     <= `CMC_RST_CONFIG;
				variant_q    <= `CMC_RST_VARIANT;
				pin_q        <= `CMC_RST_PIN;
				mfr_q        <= FACTORY_MFR;
				src_q        <= FACTORY_SRC;
				unlocked_q   <= 1'b0;
				key_hidden_q <= 1'b0;
			end else if (wr_pend_q) begin
				// unlock compare is open to all, the PIN never reads back
				if (addr_q == `CMC_OFS_UNLOCK) begin
					unlocked_q <= (hwdata == pin_q);
				end
				if (wr_ok) begin
					case (addr_q)
						`CMC_OFS_CONFIG:  config_q  <= hwdata[7:0];
						`CMC_OFS_VARIANT: variant_q <= hwdata[7:0];
						`CMC_OFS_PIN:     pin_q     <= hwdata;
						`CMC_OFS_SRC_LO:  src_q[31:0]  <= hwdata;
						`CMC_OFS_SRC_HI:  src_q[47:32] <= hwdata[15:0];
						`CMC_OFS_MFR_ID:  mfr_q     <= hwdata[15:0];
						default:          key_hidden_q <= key_hidden_q;
					endcase
					// hiding sticks until the reset gesture, later keys stay hidden
					if (addr_q[7:4] == 4'h1 && config_q[`CMC_CFG_HIDE_KEY]) begin
						key_hidden_q <= 1'b1;
					end
				end
			end
		end
	end

	// ==========================================================================
	// security key words, one per generate entry
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_key
			always @(posedge clk_sys or posedge sys_rst) begin
				if (sys_rst) begin
					key_q[gi*32 +: 32] <= 32'h00000000;
				end else if (clk_en) begin
					if (freset_q) begin
						key_q[gi*32 +: 32] <= FACTORY_KEY[gi*32 +: 32];
					end else if (wr_ok && addr_q == (`CMC_OFS_KEY0 + gi * 4)) begin
						key_q[gi*32 +: 32] <= hwdata;
					end
				end
			end
		end
	endgenerate

endmodule // cmc_top

//--- testbench/cmc_chk.sv
// Purpose: port checks of the commissioning control block
// Assumes: one clock domain, sys_rst async active high
// Notes:   hold limits follow the top's parameters
module cmc_chk #(
	parameter [31:0] T_LONG_CYC = 32'h64,
	parameter [31:0] T_TEN_CYC  = 32'h96
) (
	input wire logic       clk_sys,
	input wire logic       sys_rst,
	input wire logic       clk_en,
	input wire logic       energy_bow,
	input wire logic       hsel,
	input wire logic [1:0] htrans,
	input wire logic       hwrite,
	input wire logic       hready,
	input wire logic       hreadyout,
	input wire logic       hresp,
	input wire logic       tel_comm,
	input wire logic       tel_data,
	input wire logic       tel_press,
	input wire logic [3:0] tel_contacts,
	input wire logic       comm_mode,
	input wire logic       factory_reset_done
);
	timeunit 1ns;
	timeprecision 1ps;
	// ====================
	// bow hold counter
	logic        bow_q;
	logic [31:0] hold_q;

	// counts cycles the bow is down, keeps the count after release
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			bow_q <= 1'b0;
			hold_q <= 32'h0;
		end else if (clk_en) begin
			bow_q <= energy_bow;
			if (energy_bow)
				hold_q <= bow_q ? hold_q + 32'h1 : 32'h1;
		end
	end

	// ====================
	// properties
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst || !clk_en);
	sequence s_rd_take; hsel && htrans[1] && !hwrite && hready; endsequence
	sequence s_rd_ans; !hreadyout ##1 hreadyout; endsequence
	property p_rd_wait; s_rd_take |=> s_rd_ans; endproperty
	property p_wr_zero; hsel && htrans[1] && hwrite && hready |=> hreadyout && !hresp; endproperty
	property p_tel_pulse; (tel_comm || tel_data) |-> !(tel_comm && tel_data) ##1 (!tel_comm && !tel_data); endproperty
	property p_bow_tel; $changed(energy_bow) |-> ##[1:2] (tel_comm || tel_data); endproperty
	property p_entry_tel; $rose(comm_mode) |-> tel_comm && !tel_press; endproperty
	property p_entry_long; $rose(comm_mode) |-> hold_q >= T_LONG_CYC; endproperty
	property p_comm_only; tel_comm |-> comm_mode; endproperty
	property p_exit; $fell(comm_mode) |-> tel_data && tel_press && tel_contacts != 4'h0; endproperty
	property p_fr; factory_reset_done |-> (hold_q >= T_TEN_CYC && !energy_bow) ##1 !factory_reset_done; endproperty

	a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
	a_wr_zero: assert property (p_wr_zero) else $error("write wait wrong");
	a_tel_pulse: assert property (p_tel_pulse) else $error("telegram pulse wrong");
	a_bow_tel: assert property (p_bow_tel) else $error("bow event without telegram");
	a_entry_tel: assert property (p_entry_tel) else $error("entry without telegram");
	a_entry_long: assert property (p_entry_long) else $error("entry after short hold");
	a_comm_only: assert property (p_comm_only) else $error("telegram outside mode");
	a_exit: assert property (p_exit) else $error("mode left without press");
	a_fr: assert property (p_fr) else $error("reset done wrong");
endmodule // cmc_chk

bind cmc_top cmc_chk #(.T_LONG_CYC(T_LONG_CYC), .T_TEN_CYC(T_TEN_CYC)) u_chk (.clk_sys, .sys_rst, .energy_bow,
	.hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp, .tel_comm, .tel_data, .tel_press, .tel_contacts,
	.comm_mode, .factory_reset_done, .clk_en);

//--- testbench/cmc_btn_model.sv
// Purpose: user hand on the energy bow and four contacts
// Assumes: changes just after rising edges of clk_sys
// Notes:   contacts may let go before the bow
module cmc_btn_model (
	input  wire logic clk_sys,
	output logic       energy_bow,
	output logic [3:0] ct
);
	timeunit 1ns;
	timeprecision 1ps;
	// ====================
	// press gesture
	// all at rest from time zero
	initial begin
		energy_bow = 1'b0;
		ct = 4'h0;
	end

	// bow down for hold cycles, contacts let go after cl cycles
	task automatic press(input logic [3:0] cs, input int hold, input int cl);
		@(posedge clk_sys);
		energy_bow <= 1'b1;
		ct <= cs;
		for (int i = 1; i < hold; i++) begin
			@(posedge clk_sys);
			if (i == cl)
				ct <= 4'h0;
		end
		@(posedge clk_sys);
		energy_bow <= 1'b0;
		ct <= 4'h0;
		repeat (20) @(posedge clk_sys);
	endtask
endmodule // cmc_btn_model

//--- testbench/cmc_tb_top.sv
// Purpose: self-checking bench of the commissioning control block
// Assumes: short hold parameters, one bus master and one slave
// Notes:   telegram pulses are counted beside the register checks
`include "cmc_map.vh"
module cmc_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ====================
	// constants and signals
	localparam [127:0] FK = 128'h00112233445566778899AABBCCDDEEFF; // arbitrary value
	localparam [47:0]  FS = 48'h0A0B0C0D0E0F; // arbitrary value
	localparam [15:0]  FM = 16'h1357; // arbitrary value
	localparam [7:0]   CFG = `CMC_OFS_CONFIG, VRT = `CMC_OFS_VARIANT, PIN = `CMC_OFS_PIN, ULK = `CMC_OFS_UNLOCK;
	localparam [7:0]   KEY = `CMC_OFS_KEY0, SRC = `CMC_OFS_SRC_LO, MFR = `CMC_OFS_MFR_ID, STS = `CMC_OFS_STATUS;
	typedef struct packed {logic w; logic [7:0] a; logic [31:0] d;} cmc_row_t;
	cmc_row_t    rows [13] = '{'{1'b0, CFG, 32'h0}, '{1'b0, VRT, 32'h0}, '{1'b0, `CMC_OFS_SEQ, 32'h0},
		'{1'b0, STS, 32'h0}, '{1'b0, 8'h40, 32'h0}, '{1'b1, VRT, 32'h5A}, '{1'b0, VRT, 32'h0},
		'{1'b1, ULK, 32'hE215}, '{1'b0, STS, 32'h4}, '{1'b1, VRT, 32'h5A}, '{1'b0, VRT, 32'h5A},
		'{1'b1, KEY, 32'h11223344}, '{1'b0, KEY, 32'h11223344}};
	logic        clk_sys, sys_rst, clk_en, hsel, hwrite, energy_bow, hreadyout, hresp;
	logic        tel_comm, tel_data, tel_press, comm_mode, factory_reset_done;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [1:0]  htrans;
	logic [3:0]  ct, tel_contacts, c, nxt;
	logic [3:0]  diag [2] = '{4'h9, 4'h6};
	int          bad_count, check_count, n_tel, n_comm, n_fr, n_save;

	cmc_top #(.T_LONG_CYC(32'h64), .T_SHORT_CYC(32'h1E), .T_TEN_CYC(32'h96), .FACTORY_KEY(FK),
		.FACTORY_SRC(FS), .FACTORY_MFR(FM)) DUT (.clk_sys, .sys_rst, .clk_en, .energy_bow,
		.contact_left_low(ct[0]), .contact_left_high(ct[1]), .contact_right_low(ct[2]), .contact_right_high(ct[3]),
		.hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
		.tel_comm, .tel_data, .tel_press, .tel_contacts, .comm_mode, .factory_reset_done);
	cmc_btn_model u_btn (.clk_sys, .energy_bow, .ct);

	// ====================
	// tasks
	task ck(input logic [31:0] g, input logic [31:0] e, input string nm);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// one single transfer, address phase then data phase
	task xf(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		@(posedge clk_sys);
		while (hreadyout !== 1'b1) @(posedge clk_sys);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk_sys);
		while (hreadyout !== 1'b1) @(posedge clk_sys);
		r = hrdata;
	endtask

	task rk(input logic [7:0] a, input logic [31:0] e, input string nm);
		xf(1'b0, a, 32'h0);
		ck(r, e, nm);
	endtask

	// first press of ha cycles, middle press, long press
	task seq3(input logic [3:0] a, input logic [3:0] b, input int ha, input int hb);
		u_btn.press(a, ha, ha);
		u_btn.press(b, hb, hb);
		u_btn.press(a, 110, 110);
	endtask

	task report_and_stop;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ====================
	// clock, monitor, watchdog
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	// counts telegram and reset pulses
	always @(posedge clk_sys) begin
		if (tel_comm === 1'b1 || tel_data === 1'b1) n_tel++;
		if (tel_comm === 1'b1) n_comm++;
		if (factory_reset_done === 1'b1) n_fr++;
	end

	// cuts a hang short
	initial begin
		repeat (40000) @(posedge clk_sys);
		bad_count++;
		report_and_stop;
	end

	// ====================
	// main sequence
	initial begin
		sys_rst = 1'b1;
		clk_en = 1'b1;
		hsel = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		repeat (4) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		foreach (rows[i]) begin
			xf(rows[i].w, rows[i].a, rows[i].w ? rows[i].d : 32'h0);
			if (!rows[i].w) ck(r, rows[i].d, "table");
		end
		seq3(4'h1, 4'h1, 110, 50);
		ck(comm_mode, 1'b0, "slow middle");
		seq3(4'h2, 4'h2, 90, 10);
		ck(comm_mode, 1'b0, "short first");
		seq3(4'h4, 4'h8, 110, 10);
		ck(comm_mode, 1'b0, "other middle");
		for (int i = 0; i < 4; i++) begin
			c = 4'h1 << i;
			nxt = 4'h1 << ((i + 1) % 4);
			seq3(c, c, 110, 10);
			ck(comm_mode, 1'b1, "enter");
			rk(STS, {24'h0, c, 4'h5}, "entry contact");
			u_btn.press(c, 10, 10);
			ck(comm_mode, 1'b1, "stay");
			u_btn.press(nxt, 10, 10);
			ck(comm_mode, 1'b0, "exit");
		end
		ck(n_comm, 32'hC, "comm telegrams");
		ck(n_tel, 32'h3A, "telegrams");
		rk(`CMC_OFS_SEQ, n_tel, "sequence");
		xf(1'b1, CFG, 32'h1);
		seq3(4'h1, 4'h1, 110, 10);
		ck(comm_mode, 1'b0, "flag blocks");
		xf(1'b1, CFG, 32'h0);
		u_btn.press(4'hB, 160, 160);
		seq3(4'h1, 4'h1, 110, 10);
		ck(comm_mode, 1'b0, "gesture blocks");
		xf(1'b1, CFG, 32'h2);
		xf(1'b1, KEY, 32'h55);
		rk(KEY, 32'h0, "hidden key");
		foreach (diag[i]) begin
			xf(1'b1, PIN, 32'h12345678);
			xf(1'b1, ULK, 32'hE215);
			rk(STS, (i == 0) ? 32'h1A : 32'h10, "old pin refused");
			u_btn.press(diag[i], 160, 5);
			xf(1'b1, ULK, 32'hE215);
			rk(STS, 32'h14, "status after reset");
			rk(CFG, 32'h0, "config");
			rk(VRT, 32'h0, "variant");
			rk(KEY, FK[31:0], "key");
			rk(SRC, FS[31:0], "address");
			rk(MFR, {16'h0, FM}, "maker id");
		end
		ck(n_fr, 32'h2, "resets");
		seq3(4'h2, 4'h2, 110, 10);
		ck(comm_mode, 1'b1, "re-enabled");
		// frozen clock enable: a foreign press must go unseen
		n_save = n_tel;
		clk_en <= 1'b0;
		u_btn.press(4'h4, 10, 10);
		clk_en <= 1'b1;
		@(posedge clk_sys);
		ck(comm_mode, 1'b1, "frozen mode");
		ck(n_tel, n_save, "frozen telegrams");
		// reset in mid-run
		sys_rst <= 1'b1;
		@(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		ck(comm_mode, 1'b0, "reset mode");
		rk(STS, 32'h0, "reset status");
		rk(CFG, 32'h0, "reset config");
		rk(`CMC_OFS_SEQ, 32'h0, "reset sequence");
		report_and_stop;
	end
endmodule // cmc_tb_top
